// File: include/dsp_pkg.sv
// Shared constants and types of the display rail sequencer
package dsp_pkg;
	localparam int unsigned CLK_MHZ   = 100;
	localparam int unsigned T_ARM_US  = 1000;
	localparam int unsigned T_PCHK_US = 4000;
	localparam int unsigned T_STEP_US = 5000;
	localparam int unsigned T_UV_US   = 50000;
	localparam int unsigned T_SC_US   = 100;
	localparam int unsigned ARM_CYC   = T_ARM_US * CLK_MHZ;
	localparam int unsigned PCHK_CYC  = T_PCHK_US * CLK_MHZ;
	localparam int unsigned STEP_CYC  = T_STEP_US * CLK_MHZ;
	localparam int unsigned UV_CYC    = T_UV_US * CLK_MHZ;
	localparam int unsigned SC_CYC    = T_SC_US * CLK_MHZ;

	localparam logic [6:0] I2C_ADDR = 7'h6B;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Register offsets
	localparam logic [7:0] OFS_PVOLT = 8'h00;
	localparam logic [7:0] OFS_PDLY  = 8'h07;
	localparam logic [7:0] OFS_PSS   = 8'h08;
	localparam logic [7:0] OFS_FREQ  = 8'h0A;
	localparam logic [7:0] OFS_SLEW  = 8'h13;
	localparam logic [7:0] OFS_PROT  = 8'h14;
	localparam logic [7:0] OFS_STAT  = 8'h15;

	// Values after reset
	localparam logic [5:0] RST_PVOLT = 6'h14;
	localparam logic [3:0] RST_PDLY  = 4'h1;
	localparam logic [2:0] RST_PSS   = 3'h1;
	localparam logic [1:0] RST_FREQ  = 2'h0;
	localparam logic [1:0] RST_SLEW  = 2'h1;
	localparam logic [2:0] RST_PROT  = 3'h7;

	// Field positions
	localparam int PROT_SC  = 0;
	localparam int PROT_UV  = 1;
	localparam int PROT_OT  = 2;
	localparam int SLEW_LSB = 6;

	// Latched fault causes
	localparam logic [1:0] FC_NONE = 2'h0;
	localparam logic [1:0] FC_PRE  = 2'h1;
	localparam logic [1:0] FC_SC   = 2'h2;
	localparam logic [1:0] FC_UV   = 2'h3;

	typedef enum logic [3:0] {
		SQ_OFF, SQ_ARM, SQ_SCWAIT, SQ_DELAY, SQ_PRE, SQ_SS, SQ_RUN, SQ_SCHOLD, SQ_FAULT
	} dsp_seq_t;

	typedef enum logic [3:0] {
		LK_IDLE, LK_ADDR, LK_AACK, LK_REG, LK_RACK, LK_WDATA, LK_WACK, LK_RDATA, LK_RDACK
	} dsp_lnk_st_t;

	typedef struct packed {
		logic [5:0] volt;
		logic [3:0] dly;
		logic [2:0] ss;
		logic [1:0] freq;
		logic [1:0] slew;
		logic [2:0] prot;
	} dsp_cfg_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] ptr;
		logic [7:0] data;
	} dsp_lnk_t;
endpackage : dsp_pkg

// File: hdl/dsp_sequencer.sv
// Display rail sequencer: I2C registers, power-up sequence and fault protection
// Functional notes
// - Enable high starts power-up; enable low powers everything off.
// - Two-bit field picks 600k, 800k, 1M or 2.2MHz; resets to 600kHz.
// - Output under 70% for 50ms shuts the device down.
// - Under-voltage shutdown stays latched until supply release or new enable.
// - Protection bit 1 enables under-voltage shutdown.
// - Power-up waits until every output is below its short level.
// - Positive rail uses fixed short level until soft-start ends, then 30%.
// - Pre-power-up short check begins 1ms after supply release; code counts the 1ms from enable.
// - Positive rail below fixed level 4ms after delay end enters protection.
// - Pre-charge ends when rail is within 0.2V of input, then soft-start.
// - Negative rail short detection armed only after its soft-start.
// - Short in operation stops that channel's switches at once; if both short in one cycle code stops only the positive one.
// - 100us after a short all channels stop and fault output goes low.
// - Short shutdown stays latched until supply release or new enable.
// - Protection bit 0 enables short protection; pre-charge check always runs.
// - Over-temperature stops switching, resumes on clear; bit 2 enables it.
// - Slew field picks fast, normal, slow, slowest; resets to normal.
// - Six-bit target field at 00h, 5V to 7.3V, resets to 0x14.
// - Three-bit soft-start field at 08h, 5ms to 40ms, resets to 0x01.
// - Four-bit on-delay field at 07h, 0ms to 75ms, resets to 0x01.
// - On-delay counts from configuration load done to rail rising; code starts it when the short-check wait ends.
// - Peak-current trip turns off the positive low-side switch.
// - Device answers I2C address 1101011.
`timescale 1ns/10ps
module dsp_sequencer #(
	parameter int unsigned P_ARM_CYC  = dsp_pkg::ARM_CYC,
	parameter int unsigned P_PCHK_CYC = dsp_pkg::PCHK_CYC,
	parameter int unsigned P_STEP_CYC = dsp_pkg::STEP_CYC,
	parameter int unsigned P_UV_CYC   = dsp_pkg::UV_CYC,
	parameter int unsigned P_SC_CYC   = dsp_pkg::SC_CYC
) (
	input  wire logic       CLK_SYS,
	input  wire logic       RSTN,
	input  wire logic       EN,
	input  wire logic       NVM_LOAD_DONE,
	input  wire logic       POS_BELOW_SC,
	input  wire logic       NEG_BELOW_SC,
	input  wire logic       POS_BELOW_UV,
	input  wire logic       NEG_BELOW_UV,
	input  wire logic       POS_NEAR_VIN,
	input  wire logic       OVER_TEMP,
	input  wire logic       PEAK_TRIP,
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	output logic            POS_SW_EN,
	output logic            NEG_SW_EN,
	output logic            POS_LS_OFF,
	output logic            PRECHARGE_EN,
	output logic            SC_FIXED_SEL,
	output logic            FAULT_N,
	output logic [1:0]      FREQ_SEL,
	output logic [1:0]      SLEW_SEL,
	output logic [5:0]      VOLT_CODE
);
	dsp_pkg::dsp_seq_t    st;
	dsp_pkg::dsp_lnk_st_t lst;
	dsp_pkg::dsp_cfg_t    cfg;
	dsp_pkg::dsp_lnk_t    lw;
	logic [31:0]          tmr;
	logic [31:0]          uv_cnt;
	logic [1:0]           cause;
	logic                 sc_pos;
	logic [9:0]           s1;
	logic [9:0]           s2;
	logic                 tg3;
	logic [7:0]           ptr_sys;
	logic [7:0]           rd_data;
	logic [7:0]           sr;
	logic [7:0]           tx;
	logic [2:0]           bcnt;
	logic                 rw;
	logic                 tgl;
	logic                 start_t;
	logic                 stop_t;
	logic                 start_a;
	logic                 stop_a;
	logic                 en_s;
	logic                 nvm_s;
	logic                 psc_s;
	logic                 nsc_s;
	logic                 puv_s;
	logic                 nuv_s;
	logic                 pvin_s;
	logic                 ot_s;
	logic                 pk_s;
	logic                 lnk_ev;
	logic                 uv_hit;
	logic                 sw_ok;

	// Delay of a code in whole steps
	function automatic logic [31:0] steps(input logic [3:0] code);
		return 32'(code) * P_STEP_CYC;
	endfunction : steps

	// Register read mux
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		case (a)
			dsp_pkg::OFS_PVOLT: reg_read = {2'h0, cfg.volt};
			dsp_pkg::OFS_PDLY:  reg_read = {4'h0, cfg.dly};
			dsp_pkg::OFS_PSS:   reg_read = {5'h00, cfg.ss};
			dsp_pkg::OFS_FREQ:  reg_read = {6'h00, cfg.freq};
			dsp_pkg::OFS_SLEW:  reg_read = {cfg.slew, 6'h00};
			dsp_pkg::OFS_PROT:  reg_read = {5'h00, cfg.prot};
			dsp_pkg::OFS_STAT:  reg_read = {3'h0, st == dsp_pkg::SQ_FAULT, ot_s,
				st == dsp_pkg::SQ_RUN, cause};
			default:            reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// ---------------- Link domain (SCL) ----------------

	// Start and stop seen as SDA edges while SCL is high
	always_ff @(negedge SDA_IN or negedge RSTN) begin
		if (!RSTN) begin
			start_t <= 1'b0;
		end else if (SCL) begin
			start_t <= ~start_t;
		end
	end

	always_ff @(posedge SDA_IN or negedge RSTN) begin
		if (!RSTN) begin
			stop_t <= 1'b0;
		end else if (SCL) begin
			stop_t <= ~stop_t;
		end
	end

	// Shift in data on rising SCL
	always_ff @(posedge SCL or negedge RSTN) begin
		if (!RSTN) begin
			sr <= 8'h00;
		end else begin
			sr <= {sr[6:0], SDA_IN};
		end
	end

	// Target state machine, moves on falling SCL
	always_ff @(negedge SCL or negedge RSTN) begin
		if (!RSTN) begin
			lst     <= dsp_pkg::LK_IDLE;
			bcnt    <= 3'h0;
			rw      <= 1'b0;
			tx      <= 8'h00;
			SDA_OE  <= 1'b0;
			tgl     <= 1'b0;
			lw      <= '0;
			start_a <= 1'b0;
			stop_a  <= 1'b0;
		end else begin
			start_a <= start_t;
			stop_a  <= stop_t;
			if (start_t != start_a) begin
				lst    <= dsp_pkg::LK_ADDR;
				bcnt   <= 3'h0;
				SDA_OE <= 1'b0;
			end else if (stop_t != stop_a) begin
				lst    <= dsp_pkg::LK_IDLE;
				SDA_OE <= 1'b0;
			end else begin
				case (lst)
					dsp_pkg::LK_ADDR: begin
						bcnt <= bcnt + 3'h1;
						if (bcnt == dsp_pkg::BIT_LAST) begin
							if (sr[7:1] == dsp_pkg::I2C_ADDR) begin
								rw     <= sr[0];
								SDA_OE <= 1'b1;
								lst    <= dsp_pkg::LK_AACK;
							end else begin
								lst <= dsp_pkg::LK_IDLE;
							end
						end
					end
					dsp_pkg::LK_AACK: begin
						bcnt <= 3'h0;
						if (rw) begin
							tx     <= rd_data;
							SDA_OE <= ~rd_data[7];
							lst    <= dsp_pkg::LK_RDATA;
						end else begin
							SDA_OE <= 1'b0;
							lst    <= dsp_pkg::LK_REG;
						end
					end
					dsp_pkg::LK_REG, dsp_pkg::LK_WDATA: begin
						bcnt <= bcnt + 3'h1;
						if (bcnt == dsp_pkg::BIT_LAST) begin
							lw     <= (lst == dsp_pkg::LK_REG) ? {1'b0, sr, 8'h00}
								: {1'b1, lw.ptr, sr};
							tgl    <= ~tgl;
							SDA_OE <= 1'b1;
							lst    <= (lst == dsp_pkg::LK_REG) ? dsp_pkg::LK_RACK
								: dsp_pkg::LK_WACK;
						end
					end
					dsp_pkg::LK_RACK, dsp_pkg::LK_WACK: begin
						bcnt   <= 3'h0;
						SDA_OE <= 1'b0;
						lst    <= dsp_pkg::LK_WDATA;
					end
					dsp_pkg::LK_RDATA: begin
						bcnt <= bcnt + 3'h1;
						if (bcnt == dsp_pkg::BIT_LAST) begin
							SDA_OE <= 1'b0;
							lst    <= dsp_pkg::LK_RDACK;
						end else begin
							tx     <= {tx[6:0], 1'b0};
							SDA_OE <= ~tx[6];
						end
					end
					dsp_pkg::LK_RDACK: lst <= dsp_pkg::LK_IDLE;
					default:           lst <= dsp_pkg::LK_IDLE;
				endcase
			end
		end
	end

	// Open-drain line is only ever pulled low; held in a flop like every other output
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			SDA_OUT <= 1'b0;
		end else begin
			SDA_OUT <= 1'b0;
		end
	end

	// ---------------- System domain ----------------

	// Two-flop synchronisers for pins and the link event toggle
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			s1  <= 10'h000;
			s2  <= 10'h000;
			tg3 <= 1'b0;
		end else begin
			s1  <= {EN, NVM_LOAD_DONE, POS_BELOW_SC, NEG_BELOW_SC, POS_BELOW_UV,
				NEG_BELOW_UV, POS_NEAR_VIN, OVER_TEMP, PEAK_TRIP, tgl};
			s2  <= s1;
			tg3 <= s2[0];
		end
	end

	assign {en_s, nvm_s, psc_s, nsc_s, puv_s, nuv_s, pvin_s, ot_s, pk_s} = s2[9:1];
	assign lnk_ev = s2[0] ^ tg3;

	// Register file, written from stable link word after its toggle arrives
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			cfg.volt <= dsp_pkg::RST_PVOLT;
			cfg.dly  <= dsp_pkg::RST_PDLY;
			cfg.ss   <= dsp_pkg::RST_PSS;
			cfg.freq <= dsp_pkg::RST_FREQ;
			cfg.slew <= dsp_pkg::RST_SLEW;
			cfg.prot <= dsp_pkg::RST_PROT;
			ptr_sys  <= 8'h00;
		end else if (lnk_ev) begin
			ptr_sys <= lw.ptr;
			if (lw.wr) begin
				case (lw.ptr)
					dsp_pkg::OFS_PVOLT: cfg.volt <= lw.data[5:0];
					dsp_pkg::OFS_PDLY:  cfg.dly  <= lw.data[3:0];
					dsp_pkg::OFS_PSS:   cfg.ss   <= lw.data[2:0];
					dsp_pkg::OFS_FREQ:  cfg.freq <= lw.data[1:0];
					dsp_pkg::OFS_SLEW:  cfg.slew <= lw.data[dsp_pkg::SLEW_LSB +: 2];
					dsp_pkg::OFS_PROT:  cfg.prot <= lw.data[2:0];
					default:            cfg.prot <= cfg.prot;
				endcase
			end
		end
	end

	// Read data held stable for the link side
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= reg_read(ptr_sys);
		end
	end

	// Under-voltage persistence timer
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			uv_cnt <= 32'h0;
		end else if (st == dsp_pkg::SQ_RUN && cfg.prot[dsp_pkg::PROT_UV] && (puv_s || nuv_s)) begin
			uv_cnt <= uv_cnt + 32'h1;
		end else begin
			uv_cnt <= 32'h0;
		end
	end

	assign uv_hit = uv_cnt >= P_UV_CYC - 1;

	// Power sequence and fault latches
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			st     <= dsp_pkg::SQ_OFF;
			tmr    <= 32'h0;
			cause  <= dsp_pkg::FC_NONE;
			sc_pos <= 1'b0;
		end else if (!en_s) begin
			st    <= dsp_pkg::SQ_OFF;
			tmr   <= 32'h0;
			cause <= dsp_pkg::FC_NONE;
		end else begin
			tmr <= tmr + 32'h1;
			case (st)
				dsp_pkg::SQ_OFF: begin
					st  <= dsp_pkg::SQ_ARM;
					tmr <= 32'h0;
				end
				dsp_pkg::SQ_ARM: if (tmr >= P_ARM_CYC - 1) begin
					st  <= dsp_pkg::SQ_SCWAIT;
					tmr <= 32'h0;
				end
				dsp_pkg::SQ_SCWAIT: if (psc_s && nsc_s && nvm_s) begin
					st  <= dsp_pkg::SQ_DELAY;
					tmr <= 32'h0;
				end
				dsp_pkg::SQ_DELAY: if (tmr >= steps(cfg.dly)) begin
					st  <= dsp_pkg::SQ_PRE;
					tmr <= 32'h0;
				end
				dsp_pkg::SQ_PRE: begin
					if (tmr == P_PCHK_CYC - 1 && psc_s) begin
						st    <= dsp_pkg::SQ_FAULT;
						cause <= dsp_pkg::FC_PRE;
					end else if (pvin_s) begin
						st  <= dsp_pkg::SQ_SS;
						tmr <= 32'h0;
					end
				end
				dsp_pkg::SQ_SS: begin
					if (cfg.prot[dsp_pkg::PROT_SC] && psc_s) begin
						st     <= dsp_pkg::SQ_SCHOLD;
						sc_pos <= 1'b1;
						tmr    <= 32'h0;
					end else if (tmr >= steps(4'(cfg.ss) + 4'h1)) begin
						st  <= dsp_pkg::SQ_RUN;
						tmr <= 32'h0;
					end
				end
				dsp_pkg::SQ_RUN: begin
					if (cfg.prot[dsp_pkg::PROT_SC] && (psc_s || nsc_s)) begin
						st     <= dsp_pkg::SQ_SCHOLD;
						sc_pos <= psc_s;
						tmr    <= 32'h0;
					end else if (uv_hit) begin
						st    <= dsp_pkg::SQ_FAULT;
						cause <= dsp_pkg::FC_UV;
					end
				end
				dsp_pkg::SQ_SCHOLD: if (tmr >= P_SC_CYC - 1) begin
					st    <= dsp_pkg::SQ_FAULT;
					cause <= dsp_pkg::FC_SC;
				end
				dsp_pkg::SQ_FAULT: st <= dsp_pkg::SQ_FAULT;
				default:           st <= dsp_pkg::SQ_OFF;
			endcase
		end
	end

	assign sw_ok = !(cfg.prot[dsp_pkg::PROT_OT] && ot_s);

	// Registered drive to converters and fault pin
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			POS_SW_EN    <= 1'b0;
			NEG_SW_EN    <= 1'b0;
			POS_LS_OFF   <= 1'b0;
			PRECHARGE_EN <= 1'b0;
			SC_FIXED_SEL <= 1'b1;
			FAULT_N      <= 1'b1;
			FREQ_SEL     <= dsp_pkg::RST_FREQ;
			SLEW_SEL     <= dsp_pkg::RST_SLEW;
			VOLT_CODE    <= dsp_pkg::RST_PVOLT;
		end else begin
			POS_SW_EN    <= sw_ok && (st == dsp_pkg::SQ_SS || st == dsp_pkg::SQ_RUN
				|| (st == dsp_pkg::SQ_SCHOLD && !sc_pos));
			NEG_SW_EN    <= sw_ok && (st == dsp_pkg::SQ_SS || st == dsp_pkg::SQ_RUN
				|| (st == dsp_pkg::SQ_SCHOLD && sc_pos));
			POS_LS_OFF   <= pk_s;
			PRECHARGE_EN <= st == dsp_pkg::SQ_PRE;
			SC_FIXED_SEL <= st != dsp_pkg::SQ_RUN && st != dsp_pkg::SQ_SCHOLD;
			FAULT_N      <= st != dsp_pkg::SQ_FAULT;
			FREQ_SEL     <= cfg.freq;
			SLEW_SEL     <= cfg.slew;
			VOLT_CODE    <= cfg.volt;
		end
	end

	// ---------------- Checks ----------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);

	a_enable_off: assert property (!en_s |=> st == dsp_pkg::SQ_OFF ##1 FAULT_N)
		else $error("enable low did not power off");
	a_freq_follow: assert property (lnk_ev && lw.wr && lw.ptr == dsp_pkg::OFS_FREQ
		|=> ##1 FREQ_SEL == $past(lw.data[1:0], 2))
		else $error("frequency field not applied");
	a_uv_shutdown: assert property (en_s && st == dsp_pkg::SQ_RUN && uv_hit
		&& !(cfg.prot[dsp_pkg::PROT_SC] && (psc_s || nsc_s))
		|=> st == dsp_pkg::SQ_FAULT ##1 !FAULT_N)
		else $error("under-voltage timeout missed");
	a_fault_latched: assert property (st == dsp_pkg::SQ_FAULT && en_s
		|=> st == dsp_pkg::SQ_FAULT)
		else $error("fault latch released early");
	a_uv_disabled: assert property (!cfg.prot[dsp_pkg::PROT_UV] |=> uv_cnt == 32'h0)
		else $error("under-voltage timer ran while disabled");
	a_sc_wait: assert property (en_s && st == dsp_pkg::SQ_SCWAIT && !(psc_s && nsc_s)
		|=> st == dsp_pkg::SQ_SCWAIT)
		else $error("power-up started with an output high");
	a_arm_time: assert property (st == dsp_pkg::SQ_SCWAIT && $past(st) == dsp_pkg::SQ_ARM
		|-> $past(tmr) >= P_ARM_CYC - 1)
		else $error("short check armed too early");
	a_pchk_fault: assert property (en_s && st == dsp_pkg::SQ_PRE && tmr == P_PCHK_CYC - 1
		&& psc_s |=> st == dsp_pkg::SQ_FAULT ##1 !FAULT_N && !POS_SW_EN)
		else $error("pre-charge short check missed");
	a_sc_channel: assert property (en_s && st == dsp_pkg::SQ_RUN && cfg.prot[dsp_pkg::PROT_SC]
		&& psc_s |=> ##1 !POS_SW_EN)
		else $error("shorted channel kept switching");
	a_sc_delay: assert property (en_s && st == dsp_pkg::SQ_SCHOLD && tmr == P_SC_CYC - 1
		|=> ##1 !FAULT_N && !POS_SW_EN && !NEG_SW_EN)
		else $error("short shutdown not applied");
	a_peak_off: assert property (pk_s |=> POS_LS_OFF)
		else $error("peak trip ignored");
	a_otp_stop: assert property (cfg.prot[dsp_pkg::PROT_OT] && ot_s |=> !POS_SW_EN && !NEG_SW_EN)
		else $error("switching during over-temperature");

	c_reach_run: cover property (st == dsp_pkg::SQ_SS ##1 st == dsp_pkg::SQ_RUN);
	c_sc_fault: cover property (st == dsp_pkg::SQ_SCHOLD ##1 st == dsp_pkg::SQ_FAULT);
	c_pre_fault: cover property (st == dsp_pkg::SQ_PRE ##1 st == dsp_pkg::SQ_FAULT);
	c_reg_write: cover property (lnk_ev && lw.wr);
endmodule : dsp_sequencer

// File: test/dsp_host_model.sv
// Host I2C controller model for the rail sequencer register link
`timescale 1ns/10ps
module dsp_host_model #(
	parameter logic [5:0] VOLT_FLOOR = 6'h00
) (
	output logic      scl,
	output logic      sda,
	input  wire logic sda_oe,
	input  wire logic sda_out
);
	logic sda_m;

	// Pulled-up wire: low when either party pulls it
	assign sda = sda_m & (sda_oe ? sda_out : 1'b1);

	// Both lines idle high; the link clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// One link clock: data moves while low, line sampled while high
	task automatic bit_io(input logic b, output logic r);
		#1 sda_m = b;
		#2 scl = 1'b1;
		r = sda;
		#3 scl = 1'b0;
	endtask : bit_io

	// Start or repeated start: data falls while the clock is high
	task automatic start_cond();
		#1 sda_m = 1'b1;
		#2 scl = 1'b1;
		#3 sda_m = 1'b0;
		#3 scl = 1'b0;
	endtask : start_cond

	// Stop, then the clock stands high
	task automatic stop_cond();
		#1 sda_m = 1'b0;
		#2 scl = 1'b1;
		#3 sda_m = 1'b1;
		#3;
	endtask : stop_cond

	// Eight bits MSB first, ninth bit released (ack in, or nack out)
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : byte_io

	// Register write: address, offset, one data byte
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
		input logic [7:0] d, output logic ok);
		logic [7:0] rx, v;
		logic       a0, a1, a2;
		v = d;
		if (ofs == dsp_pkg::OFS_PVOLT && d[5:0] < VOLT_FLOOR) begin
			v = {d[7:6], VOLT_FLOOR};
		end
		start_cond();
		byte_io({dev, 1'b0}, rx, a0);
		byte_io(ofs, rx, a1);
		byte_io(v, rx, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : write_reg

	// Register read: pointer write, gap for the crossing, one byte with nack
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
		output logic [7:0] d, output logic ok);
		logic [7:0] rx;
		logic       a0, a1, a2, a3;
		start_cond();
		byte_io({dev, 1'b0}, rx, a0);
		byte_io(ofs, rx, a1);
		#1500;
		start_cond();
		byte_io({dev, 1'b1}, rx, a2);
		byte_io(8'hFF, d, a3);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : dsp_host_model

// File: test/dsp_sequencer_test.sv
// Self-checking bench for the rail sequencer: register link, sequence, protection
`timescale 1ns/10ps
module dsp_sequencer_test;
	localparam int ARM  = 20;
	localparam int PCHK = 40;
	localparam int STEP = 50;
	localparam int UV   = 60;
	localparam int SC   = 10;
	localparam int PUP  = ARM + 2 * STEP;

	logic       clk, rstn, en, nvm, pos_sc, neg_sc, pos_uv, neg_uv, near, hot, peak;
	logic       scl, sda, sda_out, sda_oe, ok;
	logic       pos_en, neg_en, ls_off, pre_en, fix_sel, fault_n;
	logic [1:0] freq, slew;
	logic [5:0] volt;
	int         err_total, n_compared;
	string      names [0:8] = '{"pos_sw_en", "neg_sw_en", "precharge_en", "fault_n",
		"sc_fixed_sel", "pos_ls_off", "freq_sel", "slew_sel", "volt_code"};
	logic [7:0] t_ofs [0:5] = '{8'h00, 8'h07, 8'h08, 8'h0A, 8'h13, 8'h14};
	logic [7:0] t_rst [0:5] = '{8'h14, 8'h01, 8'h01, 8'h00, 8'h40, 8'h07};
	logic [7:0] t_msk [0:5] = '{8'h3F, 8'h0F, 8'h07, 8'h03, 8'hC0, 8'h07};
	logic [7:0] p_rst [0:8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01,
		8'h14};

	dsp_sequencer #(
		.P_ARM_CYC (ARM),
		.P_PCHK_CYC(PCHK),
		.P_STEP_CYC(STEP),
		.P_UV_CYC  (UV),
		.P_SC_CYC  (SC)
	) dsp_sequencer_inst (
		.CLK_SYS(clk), .RSTN(rstn), .EN(en), .NVM_LOAD_DONE(nvm),
		.POS_BELOW_SC(pos_sc), .NEG_BELOW_SC(neg_sc), .POS_BELOW_UV(pos_uv),
		.NEG_BELOW_UV(neg_uv), .POS_NEAR_VIN(near), .OVER_TEMP(hot), .PEAK_TRIP(peak),
		.SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.POS_SW_EN(pos_en), .NEG_SW_EN(neg_en), .POS_LS_OFF(ls_off),
		.PRECHARGE_EN(pre_en), .SC_FIXED_SEL(fix_sel), .FAULT_N(fault_n),
		.FREQ_SEL(freq), .SLEW_SEL(slew), .VOLT_CODE(volt)
	);

	dsp_host_model dsp_host_model_inst (
		.scl(scl), .sda(sda), .sda_oe(sda_oe), .sda_out(sda_out)
	);

	// System clock, 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Output selected by index, widened to a byte
	function automatic logic [7:0] probe(input int sel);
		case (sel)
			0: probe = {7'h00, pos_en};
			1: probe = {7'h00, neg_en};
			2: probe = {7'h00, pre_en};
			3: probe = {7'h00, fault_n};
			4: probe = {7'h00, fix_sel};
			5: probe = {7'h00, ls_off};
			6: probe = {6'h00, freq};
			7: probe = {6'h00, slew};
			8: probe = {2'h0, volt};
			default: probe = 8'h00;
		endcase
	endfunction : probe

	task automatic pin(input int sel, input logic [7:0] exp);
		@(negedge clk);
		chk(names[sel], probe(sel), exp);
	endtask : pin

	// Bounded wait for an output value, then a check on the cycle window
	task automatic wait_sel(input int sel, input logic [7:0] val, input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (probe(sel) !== val && n < hi);
		chk(names[sel], probe(sel), val);
		if (probe(sel) !== val) close_out();
		chk("cycles_in_window", {7'h00, (n >= lo)}, 8'h01);
	endtask : wait_sel

	task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
		dsp_host_model_inst.write_reg(dsp_pkg::I2C_ADDR, ofs, d, ok);
		chk("write_ack", {7'h00, ok}, 8'h01);
		cyc(6);
	endtask : wreg

	task automatic rreg(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		dsp_host_model_inst.read_reg(dsp_pkg::I2C_ADDR, ofs, d, ok);
		chk("read_ack", {7'h00, ok}, 8'h01);
		chk("read_data", d, exp);
	endtask : rreg

	// From the enabling edge through pre-charge and soft-start into run
	task automatic power_up(input int lo, input int hi);
		wait_sel(2, 8'h01, lo, hi);
		cyc(1);
		pos_sc <= 1'b0;
		cyc(PCHK + 20);
		pin(2, 8'h01);
		pin(0, 8'h00);
		cyc(1);
		near <= 1'b1;
		wait_sel(0, 8'h01, 1, 8);
		pin(2, 8'h00);
		pin(4, 8'h01);
		cyc(15);
		pin(1, 8'h01);
		cyc(1);
		neg_sc <= 1'b0;
		wait_sel(4, 8'h00, 22, 40);
		pin(3, 8'h01);
	endtask : power_up

	task automatic power_down();
		cyc(1);
		en <= 1'b0;
		pos_sc <= 1'b1;
		neg_sc <= 1'b1;
		near <= 1'b0;
		wait_sel(0, 8'h00, 0, 8);
		wait_sel(3, 8'h01, 0, 8);
		pin(1, 8'h00);
		pin(2, 8'h00);
		cyc(4);
	endtask : power_down

	task automatic close_out();
		if (err_total == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	// Main sequence
	initial begin
		err_total = 0;
		n_compared = 0;
		rstn = 1'b0;
		en = 1'b0;
		nvm = 1'b1;
		pos_sc = 1'b1;
		neg_sc = 1'b1;
		pos_uv = 1'b0;
		neg_uv = 1'b0;
		near = 1'b0;
		hot = 1'b0;
		peak = 1'b0;
		cyc(6);
		rstn <= 1'b1;
		cyc(2);
		for (int s = 0; s < 9; s++) pin(s, p_rst[s]);
		// Register table: reset value, all-ones write, masked readback
		for (int i = 0; i < 6; i++) begin
			rreg(t_ofs[i], t_rst[i]);
			wreg(t_ofs[i], 8'hFF);
			rreg(t_ofs[i], t_msk[i]);
		end
		pin(8, 8'h3F);
		wreg(8'h15, 8'hFF);
		rreg(8'h15, 8'h00);
		wreg(8'h30, 8'hFF);
		rreg(8'h30, 8'h00);
		for (int i = 0; i < 6; i++) wreg(t_ofs[i], t_rst[i]);
		for (int c = 0; c < 4; c++) begin
			wreg(8'h0A, 8'(c));
			wreg(8'h13, 8'(c << 6));
			pin(6, 8'(c));
			pin(7, 8'(c));
		end
		dsp_host_model_inst.write_reg(dsp_pkg::I2C_ADDR ^ 7'h01, 8'h00, 8'h21, ok);
		chk("foreign_ack", {7'h00, ok}, 8'h00);
		pin(8, 8'h14);
		wreg(8'h07, 8'h02);
		wreg(8'h08, 8'h00);
		// Run 1: late config load and undischarged rail hold the start
		cyc(1);
		nvm <= 1'b0;
		pos_sc <= 1'b0;
		en <= 1'b1;
		cyc(ARM + 40);
		pin(2, 8'h00);
		cyc(1);
		pos_sc <= 1'b1;
		cyc(60);
		pin(2, 8'h00);
		cyc(1);
		nvm <= 1'b1;
		power_up(2 * STEP - 4, 2 * STEP + 12);
		cyc(1);
		peak <= 1'b1;
		wait_sel(5, 8'h01, 1, 8);
		cyc(1);
		peak <= 1'b0;
		wait_sel(5, 8'h00, 1, 8);
		cyc(1);
		hot <= 1'b1;
		wait_sel(0, 8'h00, 1, 8);
		pin(1, 8'h00);
		cyc(1);
		hot <= 1'b0;
		wait_sel(0, 8'h01, 1, 8);
		wreg(8'h14, 8'h03);
		cyc(1);
		hot <= 1'b1;
		cyc(20);
		pin(0, 8'h01);
		cyc(1);
		hot <= 1'b0;
		wreg(8'h14, 8'h07);
		cyc(1);
		pos_sc <= 1'b1;
		wait_sel(0, 8'h00, 1, 8);
		pin(1, 8'h01);
		wait_sel(3, 8'h00, SC - 4, SC + 6);
		pin(1, 8'h00);
		cyc(1);
		pos_sc <= 1'b0;
		cyc(30);
		pin(3, 8'h00);
		rreg(8'h15, 8'h12);
		power_down();
		// Run 2: rail never clears the fixed level in pre-charge, short protection off
		wreg(8'h14, 8'h06);
		cyc(1);
		en <= 1'b1;
		wait_sel(2, 8'h01, PUP - 4, PUP + 12);
		wait_sel(3, 8'h00, PCHK - 4, PCHK + 6);
		pin(0, 8'h00);
		rreg(8'h15, 8'h11);
		power_down();
		// Run 3: short protection off in run, then a normal power-off
		cyc(1);
		en <= 1'b1;
		power_up(PUP - 4, PUP + 12);
		cyc(1);
		pos_sc <= 1'b1;
		cyc(SC + 20);
		pin(0, 8'h01);
		pin(3, 8'h01);
		cyc(1);
		pos_sc <= 1'b0;
		rreg(8'h15, 8'h04);
		power_down();
		// Run 4: under-voltage ignored while disabled, then latched
		wreg(8'h14, 8'h05);
		cyc(1);
		en <= 1'b1;
		power_up(PUP - 4, PUP + 12);
		cyc(1);
		pos_uv <= 1'b1;
		cyc(UV + 30);
		pin(3, 8'h01);
		cyc(1);
		pos_uv <= 1'b0;
		wreg(8'h14, 8'h07);
		cyc(1);
		neg_uv <= 1'b1;
		wait_sel(3, 8'h00, UV - 4, UV + 8);
		pin(0, 8'h00);
		cyc(1);
		neg_uv <= 1'b0;
		cyc(30);
		pin(3, 8'h00);
		rreg(8'h15, 8'h13);
		power_down();
		close_out();
	end
endmodule : dsp_sequencer_test
